/* File: core/iodc_pkg.sv */
package iodc_pkg;

  // serial frame byte addresses; low byte is even, high byte odd
  localparam logic [5:0] IODC_ADDR_AUX  = 6'h30;
  localparam logic [5:0] IODC_ADDR_GPIO = 6'h32;
  localparam logic [5:0] IODC_ADDR_MISC = 6'h34;
  localparam logic [5:0] IODC_ADDR_SMPL = 6'h36;
  localparam logic [5:0] IODC_ADDR_DIAG = 6'h3C;
  localparam logic [5:0] IODC_ADDR_GCMD = 6'h3E;

  // reset values
  localparam logic [15:0] IODC_GPIO_RST = 16'h0000;
  localparam logic [15:0] IODC_MISC_RST = 16'h0006;
  localparam logic [15:0] IODC_AUX_RST  = 16'h0000;
  localparam logic [15:0] IODC_SMPL_RST = 16'h0001;
  localparam logic [15:0] IODC_DIAG_RST = 16'h0000;

  // writable bit masks
  localparam logic [15:0] IODC_GPIO_WMASK = 16'h0F0F;
  localparam logic [15:0] IODC_MISC_WMASK = 16'h0FC7;
  localparam logic [15:0] IODC_AUX_WMASK  = 16'h0FFF;
  localparam logic [15:0] IODC_SMPL_WMASK = 16'h00FF;

  // field positions
  localparam int IODC_GPIO_DIR_LSB = 0;
  localparam int IODC_GPIO_LVL_LSB = 8;
  localparam int IODC_MISC_DRSEL   = 0;
  localparam int IODC_MISC_DRPOL   = 1;
  localparam int IODC_MISC_DREN    = 2;
  localparam int IODC_MISC_ALIGN   = 6;
  localparam int IODC_MISC_GCOMP   = 7;
  localparam int IODC_MISC_STPOS   = 8;
  localparam int IODC_MISC_STNEG   = 9;
  localparam int IODC_MISC_STRUN   = 10;
  localparam int IODC_MISC_MTEST   = 11;
  localparam int IODC_GCMD_LATCH   = 2;
  localparam int IODC_SMPL_TB      = 7;
  localparam int IODC_DIAG_STERR   = 5;
  localparam int IODC_DIAG_FLASH   = 6;
  localparam int IODC_DIAG_ST_LSB  = 10;
  localparam logic [15:0] IODC_DIAG_KEEP = 16'h0003;

  // timing
  localparam int IODC_CLK_PS     = 20_000;
  localparam int IODC_DRDY_MIN_PS = 100_000_000;
  localparam int IODC_DRDY_MAX_PS = 200_000_000;
  localparam int IODC_DRDY_CYC =
    (IODC_DRDY_MIN_PS + IODC_CLK_PS - 1) / IODC_CLK_PS;
  localparam int IODC_DRDY_MAX_CYC = IODC_DRDY_MAX_PS / IODC_CLK_PS;
  localparam longint IODC_TB0_PS = 64'd610_350_000;
  localparam longint IODC_TB1_PS = 64'd18_921_000_000;
  localparam int IODC_TB0_CYC = int'(IODC_TB0_PS / IODC_CLK_PS);
  localparam int IODC_TB1_CYC = int'(IODC_TB1_PS / IODC_CLK_PS);

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe_n;
  } iodc_pins_s;

  typedef struct packed {
    logic en;
    logic pol;
    logic sel;
    logic active;
  } iodc_alarm_s;

  typedef struct packed {
    logic       alarm2;
    logic       alarm1;
    logic       overrange;
    logic       comm_fail;
    logic       flash_upd_fail;
    logic       supply_hi;
    logic       supply_lo;
  } iodc_diag_ev_s;

endpackage

/* File: core/iodc_drdy.sv */
`timescale 1ns/1ps
module iodc_drdy
  import iodc_pkg::*;
#(
  parameter int unsigned PULSE_CYC = IODC_DRDY_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  input  wire logic tick_i,
  input  wire logic en_i,
  output logic      pulse_o
);

  typedef struct packed {
    logic [13:0] cnt;
    logic        pulse;
  } iodc_drdy_s;

  iodc_drdy_s st_ff;
  iodc_drdy_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // ticks during a pulse are dropped so the width stays bounded
    if (st_ff.cnt != 14'h0000) begin
      nxt_st.cnt = st_ff.cnt - 14'h0001; // [R7]
    end else if (tick_i && en_i) begin
      nxt_st.cnt = PULSE_CYC[13:0]; // [R23]
    end
    nxt_st.pulse = (nxt_st.cnt != 14'h0000);
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pulse_o = st_ff.pulse;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  logic [13:0] len_ff;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      len_ff <= '0;
    end else begin
      len_ff <= pulse_o ? len_ff + 14'h0001 : 14'h0000;
    end
  end

  a_pulse_width: assert property ( // [R7]
    $fell(pulse_o) |-> len_ff == PULSE_CYC[13:0])
    else $error("data ready pulse width wrong");
  a_pulse_start: assert property ( // [R23]
    tick_i && en_i && !pulse_o |=> pulse_o)
    else $error("data ready pulse missing after sample");
  c_pulse: cover property ($fell(pulse_o));

endmodule

/* File: core/iodc_diag.sv */
`timescale 1ns/1ps
module iodc_diag
  import iodc_pkg::*;
(
  input  wire logic          clk_sys_i,
  input  wire logic          arst_n_i,
  input  wire logic          tick_i,
  input  wire logic          rd_clr_i,
  input  wire iodc_diag_ev_s ev_i,
  input  wire logic          st_done_i,
  input  wire logic [5:0]    st_fail_i,
  input  wire logic          mem_done_i,
  input  wire logic          mem_fail_i,
  output logic [15:0]        diag_o
);

  typedef struct packed {
    logic [15:0] flags;
  } iodc_diag_st_s;

  iodc_diag_st_s st_ff;
  iodc_diag_st_s nxt_st;
  logic [15:0]   set_v;

  always_comb begin
    set_v = 16'h0000;
    if (tick_i) begin
      set_v[9] = ev_i.alarm2; // [R19] [R15]
      set_v[8] = ev_i.alarm1;
      set_v[4] = ev_i.overrange; // [R20]
      set_v[3] = ev_i.comm_fail;
      set_v[2] = ev_i.flash_upd_fail;
    end
    if (st_done_i) begin
      set_v[IODC_DIAG_ST_LSB +: 6] = st_fail_i; // [R18] [R10]
      set_v[IODC_DIAG_STERR] = |st_fail_i; // [R20]
    end
    if (mem_done_i) begin
      set_v[IODC_DIAG_FLASH] = mem_fail_i; // [R12]
    end
    nxt_st = st_ff;
    if (rd_clr_i) begin
      nxt_st.flags = st_ff.flags & IODC_DIAG_KEEP; // [R14]
    end
    // a set in the clearing cycle survives
    nxt_st.flags = nxt_st.flags | set_v;
    nxt_st.flags[1] = ev_i.supply_hi; // [R16] [R17]
    nxt_st.flags[0] = ev_i.supply_lo;
    nxt_st.flags[7] = 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= IODC_DIAG_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign diag_o = st_ff.flags;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  a_read_clear: assert property ( // [R14]
    rd_clr_i && !tick_i && !st_done_i && !mem_done_i
    |=> diag_o[15:2] == 14'h0000)
    else $error("diagnostic read did not clear flags");
  a_supply_track: assert property ( // [R16]
    ##1 diag_o[1:0] == $past({ev_i.supply_hi, ev_i.supply_lo}))
    else $error("supply flags not tracking condition");
  a_reset_again: assert property ( // [R15]
    tick_i && ev_i.overrange |=> diag_o[4])
    else $error("overrange flag not set again");
  c_read_clear: cover property (rd_clr_i && diag_o[4]);

endmodule

/* File: core/iodc_core.sv */
`timescale 1ns/1ps
// Overview of operation
// R1: line owner priority: data ready first, then alarm, then plain I/O.
// R2: I/O control bits 3..0 set line direction, 1 output, 0 input.
// R3: level bits 11..8 read input pins, drive written level on outputs.
// R4: line four input with sample period zero selects external sample clock.
// R5: misc control resets to 0x0006, data ready high on line one.
// R6: misc bit 2 enable, bit 1 polarity, bit 0 line two select.
// R7: data ready pulse lasts between 100 and 200 microseconds.
// R8: converter code loads from the DAC register only on latch command.
// R9: DAC register holds a 12-bit code, upper four bits unused.
// R10: misc bit 10 runs self-test, records results, then clears itself.
// R11: misc bits 9 and 8 apply negative and positive stimulus while set.
// R12: misc bit 11 runs memory checksum; fail to flag 6; bit clears after.
// R13: misc bit 7 gyro bias compensation, bit 6 origin alignment.
// R14: reading diagnostic status clears all flags except supply flags.
// R15: a still present error sets its flag again next sample.
// R16: supply flags clear by themselves when voltage returns in range.
// R17: diagnostic bit 1 supply high, bit 0 supply low.
// R18: diagnostic bits 15..10 report sensor self-test failures.
// R19: diagnostic bits 9 and 8 show second and first alarm.
// R20: bits 5..2 flag self-test, overrange, serial and update failures.
// R21: global command bit 2 triggers the latch and reads back as zero.
// R22: sample period low byte: bit 7 time base, bits 6..0 count.
// R23: one data ready pulse per completed sample update.
// R24: host writes both DAC bytes before issuing the latch command.
module iodc_core
  import iodc_pkg::*;
#(
  parameter int unsigned DRDY_CYC = IODC_DRDY_CYC,
  parameter int unsigned TB0_CYC  = IODC_TB0_CYC,
  parameter int unsigned TB1_CYC  = IODC_TB1_CYC
) (
  input  wire logic          clk_sys_i,
  input  wire logic          arst_n_i,
  input  wire logic          wr_en_i,
  input  wire logic [5:0]    wr_addr_i,
  input  wire logic [7:0]    wr_data_i,
  input  wire logic          rd_en_i,
  input  wire logic [5:0]    rd_addr_i,
  output logic [15:0]        rd_data_o,
  input  wire logic [3:0]    line_in_i,
  output iodc_pins_s         line_o,
  input  wire iodc_alarm_s   alarm_i,
  input  wire iodc_diag_ev_s diag_ev_i,
  input  wire logic          st_done_i,
  input  wire logic [5:0]    st_fail_i,
  input  wire logic          mem_done_i,
  input  wire logic          mem_fail_i,
  output logic               sample_tick_o,
  output logic               ext_clk_sel_o,
  output logic [11:0]        dac_code_o,
  output logic               st_run_o,
  output logic               st_neg_o,
  output logic               st_pos_o,
  output logic               mem_test_run_o,
  output logic               gyro_comp_o,
  output logic               accel_align_o
);

  typedef struct packed {
    logic [15:0] gpio;
    logic [15:0] misc;
    logic [15:0] aux;
    logic [15:0] smpl;
    logic [11:0] dac;
    logic [15:0] rd_data;
    logic [19:0] tb_cnt;
    logic [6:0]  ns_cnt;
    logic        ext_q;
    logic        tick;
    logic        drdy_en;
    iodc_pins_s  pins;
  } iodc_core_s;

  iodc_core_s st_ff;
  iodc_core_s nxt_st;

  logic        drdy_pulse;
  logic [15:0] diag;
  logic        diag_rd;
  logic        ext_sel;
  logic        tb_wrap;
  logic [19:0] tb_len;
  logic [3:0]  lvl_rd;

  function automatic logic [15:0] put_byte(
    input logic [15:0] old_v,
    input logic        hi,
    input logic [7:0]  data,
    input logic [15:0] mask
  );
    logic [15:0] v;
    v = old_v;
    if (hi) begin
      v[15:8] = data;
    end else begin
      v[7:0] = data;
    end
    return (v & mask) | (old_v & ~mask);
  endfunction

  function automatic logic [4:0] word_of(input logic [5:0] a);
    return a[5:1];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // sub blocks

  iodc_drdy #(
    .PULSE_CYC (DRDY_CYC)
  ) u_drdy (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .tick_i    (st_ff.tick),
    .en_i      (st_ff.misc[IODC_MISC_DREN]),
    .pulse_o   (drdy_pulse)
  );

  iodc_diag u_diag (
    .clk_sys_i  (clk_sys_i),
    .arst_n_i   (arst_n_i),
    .tick_i     (st_ff.tick),
    .rd_clr_i   (diag_rd),
    .ev_i       (diag_ev_i),
    .st_done_i  (st_done_i && st_ff.misc[IODC_MISC_STRUN]),
    .st_fail_i  (st_fail_i),
    .mem_done_i (mem_done_i && st_ff.misc[IODC_MISC_MTEST]),
    .mem_fail_i (mem_fail_i),
    .diag_o     (diag)
  );

  ////////////////////////////////////////////////////////////////////////
  // sample timing and register updates

  assign ext_sel = !st_ff.gpio[IODC_GPIO_DIR_LSB + 3] &&
                   st_ff.smpl[7:0] == 8'h00; // [R4]
  assign tb_len  = st_ff.smpl[IODC_SMPL_TB] ? TB1_CYC[19:0]
                                            : TB0_CYC[19:0]; // [R22]
  assign tb_wrap = st_ff.tb_cnt >= tb_len - 20'h0_0001;
  assign diag_rd = rd_en_i && word_of(rd_addr_i) ==
                   word_of(IODC_ADDR_DIAG); // [R14]

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lvl_rd[i] = st_ff.gpio[IODC_GPIO_DIR_LSB + i]
                ? st_ff.gpio[IODC_GPIO_LVL_LSB + i] : line_in_i[i]; // [R3]
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    nxt_st.ext_q = line_in_i[3];
    if (ext_sel) begin
      nxt_st.tb_cnt = 20'h0_0000;
      nxt_st.ns_cnt = 7'h00;
      nxt_st.tick = line_in_i[3] && !st_ff.ext_q; // [R4]
    end else if (tb_wrap) begin
      nxt_st.tb_cnt = 20'h0_0000;
      if (st_ff.ns_cnt >= st_ff.smpl[6:0]) begin
        nxt_st.ns_cnt = 7'h00;
        nxt_st.tick = 1'b1; // [R22]
      end else begin
        nxt_st.ns_cnt = st_ff.ns_cnt + 7'h01;
      end
    end else begin
      nxt_st.tb_cnt = st_ff.tb_cnt + 20'h0_0001;
    end

    if (st_done_i) begin
      nxt_st.misc[IODC_MISC_STRUN] = 1'b0; // [R10]
    end
    if (mem_done_i) begin
      nxt_st.misc[IODC_MISC_MTEST] = 1'b0; // [R12]
    end

    if (wr_en_i) begin
      unique case (word_of(wr_addr_i))
        word_of(IODC_ADDR_GPIO):
          nxt_st.gpio = put_byte(st_ff.gpio, wr_addr_i[0], wr_data_i,
                                 IODC_GPIO_WMASK); // [R2]
        word_of(IODC_ADDR_MISC):
          nxt_st.misc = put_byte(nxt_st.misc, wr_addr_i[0], wr_data_i,
                                 IODC_MISC_WMASK); // [R6]
        word_of(IODC_ADDR_AUX):
          nxt_st.aux = put_byte(st_ff.aux, wr_addr_i[0], wr_data_i,
                                IODC_AUX_WMASK); // [R9]
        word_of(IODC_ADDR_SMPL):
          nxt_st.smpl = put_byte(st_ff.smpl, wr_addr_i[0], wr_data_i,
                                 IODC_SMPL_WMASK); // [R22]
        word_of(IODC_ADDR_GCMD):
          if (!wr_addr_i[0] && wr_data_i[IODC_GCMD_LATCH]) begin
            nxt_st.dac = st_ff.aux[11:0]; // [R8] [R21]
          end
        default: ;
      endcase
    end

    if (rd_en_i) begin
      unique case (word_of(rd_addr_i))
        word_of(IODC_ADDR_GPIO):
          nxt_st.rd_data = {4'h0, lvl_rd, 4'h0,
                            st_ff.gpio[3:0]}; // [R3]
        word_of(IODC_ADDR_MISC): nxt_st.rd_data = st_ff.misc;
        word_of(IODC_ADDR_AUX):  nxt_st.rd_data = st_ff.aux;
        word_of(IODC_ADDR_SMPL): nxt_st.rd_data = st_ff.smpl;
        word_of(IODC_ADDR_DIAG): nxt_st.rd_data = diag;
        default:                 nxt_st.rd_data = 16'h0000; // [R21]
      endcase
    end

    // line ownership, oe_n low drives
    for (int i = 0; i < 4; i++) begin
      nxt_st.pins.oe_n[i] = !st_ff.gpio[IODC_GPIO_DIR_LSB + i];
      nxt_st.pins.o[i] = st_ff.gpio[IODC_GPIO_LVL_LSB + i]; // [R2] [R3]
      if (alarm_i.en && i == int'(alarm_i.sel)) begin
        nxt_st.pins.oe_n[i] = 1'b0; // [R1]
        nxt_st.pins.o[i] = alarm_i.active ~^ alarm_i.pol;
      end
      if (st_ff.misc[IODC_MISC_DREN] &&
          i == int'(st_ff.misc[IODC_MISC_DRSEL])) begin
        nxt_st.pins.oe_n[i] = 1'b0; // [R1] [R6]
        nxt_st.pins.o[i] = drdy_pulse ~^ st_ff.misc[IODC_MISC_DRPOL];
      end
    end
    nxt_st.drdy_en = st_ff.misc[IODC_MISC_DREN];
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '0;
      st_ff.gpio <= IODC_GPIO_RST;
      st_ff.misc <= IODC_MISC_RST; // [R5]
      st_ff.aux <= IODC_AUX_RST;
      st_ff.smpl <= IODC_SMPL_RST;
      st_ff.pins.oe_n <= 4'hF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign rd_data_o      = st_ff.rd_data;
  assign line_o         = st_ff.pins;
  assign sample_tick_o  = st_ff.tick;
  assign ext_clk_sel_o  = ext_sel;
  assign dac_code_o     = st_ff.dac;
  assign st_run_o       = st_ff.misc[IODC_MISC_STRUN]; // [R10]
  assign st_neg_o       = st_ff.misc[IODC_MISC_STNEG]; // [R11]
  assign st_pos_o       = st_ff.misc[IODC_MISC_STPOS]; // [R11]
  assign mem_test_run_o = st_ff.misc[IODC_MISC_MTEST]; // [R12]
  assign gyro_comp_o    = st_ff.misc[IODC_MISC_GCOMP]; // [R13]
  assign accel_align_o  = st_ff.misc[IODC_MISC_ALIGN]; // [R13]

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  a_dac_latch_copy: assert property ( // [R8]
    wr_en_i && wr_addr_i == IODC_ADDR_GCMD && wr_data_i[2]
    |=> dac_code_o == $past(st_ff.aux[11:0]))
    else $error("latch did not copy DAC register");
  a_dac_hold_write: assert property ( // [R8]
    wr_en_i && word_of(wr_addr_i) == word_of(IODC_ADDR_AUX)
    |=> $stable(dac_code_o))
    else $error("DAC register write reached converter");
  a_drdy_owner: assert property ( // [R1]
    st_ff.misc[2] && !st_ff.misc[0] |=> !line_o.oe_n[0])
    else $error("data ready does not own line one");
  a_drdy_level: assert property ( // [R6]
    st_ff.drdy_en && !st_ff.misc[0] && $stable(st_ff.misc)
    |-> line_o.o[0] == ($past(drdy_pulse) ~^ st_ff.misc[1]))
    else $error("data ready level or polarity wrong");
  a_gpio_dir: assert property ( // [R2]
    !st_ff.misc[2] && !alarm_i.en |=>
    line_o.oe_n[3:2] == ~$past(st_ff.gpio[3:2]))
    else $error("line direction does not follow control");
  a_gpio_read: assert property ( // [R3]
    rd_en_i && rd_addr_i == IODC_ADDR_GPIO && !st_ff.gpio[2]
    |=> rd_data_o[10] == $past(line_in_i[2]))
    else $error("input level not returned on read");
  a_ext_tick: assert property ( // [R4]
    ext_sel && line_in_i[3] && !st_ff.ext_q |=> sample_tick_o)
    else $error("external clock edge gave no sample");
  a_selftest_end: assert property ( // [R10]
    st_done_i && st_run_o && !wr_en_i |=> !st_run_o)
    else $error("self-test bit not cleared");
  a_memtest_end: assert property ( // [R12]
    mem_done_i && !wr_en_i |=> !mem_test_run_o)
    else $error("memory test bit not cleared");
  a_gcmd_reads_zero: assert property ( // [R21]
    rd_en_i && rd_addr_i == IODC_ADDR_GCMD |=> rd_data_o == 16'h0000)
    else $error("global command did not read zero");
  a_internal_rate: assert property ( // [R22]
    sample_tick_o && !ext_sel |-> st_ff.ns_cnt == 7'h00)
    else $error("internal sample count not restarted");

  c_latch: cover property (wr_en_i && wr_addr_i == IODC_ADDR_GCMD);
  c_ext_clk: cover property (ext_sel && sample_tick_o);
  c_selftest: cover property (st_run_o ##1 !st_run_o);

endmodule

/* File: bench/iodc_host.sv */
`timescale 1ns/1ps
module iodc_host
  import iodc_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] rd_data_i,
  output logic             wr_en_o,
  output logic [5:0]       wr_addr_o,
  output logic [7:0]       wr_data_o,
  output logic             rd_en_o,
  output logic [5:0]       rd_addr_o
);
  initial begin
    wr_en_o   = 1'b0;
    wr_addr_o = 6'h00;
    wr_data_o = 8'h00;
    rd_en_o   = 1'b0;
    rd_addr_o = 6'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // low byte then high byte on consecutive cycles
  task automatic wr16(input logic [5:0] a, input logic [15:0] v);
    @(negedge clk_sys_i);
    wr_en_o   = 1'b1;
    wr_addr_o = a;
    wr_data_o = v[7:0];
    @(negedge clk_sys_i);
    wr_addr_o = a | 6'h01;
    wr_data_o = v[15:8];
    @(negedge clk_sys_i);
    wr_en_o   = 1'b0;
    // released bus shows no stale byte
    wr_data_o = ~wr_data_o;
  endtask

  task automatic rd16(input logic [5:0] a, output logic [15:0] v);
    @(negedge clk_sys_i);
    rd_en_o   = 1'b1;
    rd_addr_o = a;
    @(negedge clk_sys_i);
    rd_en_o   = 1'b0;
    rd_addr_o = ~a;
    v         = rd_data_i;
  endtask
endmodule

/* File: bench/test_io_and_diagnostic_control.sv */
`timescale 1ns/1ps
module test_io_and_diagnostic_control;
  import iodc_pkg::*;
  localparam int unsigned DRC = 8;
  logic          clk_sys_i, arst_n_i, wr_en, rd_en, tick, ext_sel;
  logic [5:0]    wr_addr, rd_addr, st_fail;
  logic [7:0]    wr_data;
  logic [15:0]   rd_data;
  logic [3:0]    line_in;
  iodc_pins_s    line;
  iodc_alarm_s   alarm;
  iodc_diag_ev_s dev;
  logic          st_done, mem_done, mem_fail, st_run, st_neg, st_pos;
  logic          mem_run, gcomp, align;
  logic [11:0]   dac;
  int            bad_count, cmp_count;

  iodc_core #(.DRDY_CYC(DRC), .TB0_CYC(10), .TB1_CYC(20)) u_dut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .wr_en_i(wr_en),
    .wr_addr_i(wr_addr), .wr_data_i(wr_data), .rd_en_i(rd_en),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .line_in_i(line_in),
    .line_o(line), .alarm_i(alarm), .diag_ev_i(dev),
    .st_done_i(st_done), .st_fail_i(st_fail), .mem_done_i(mem_done),
    .mem_fail_i(mem_fail), .sample_tick_o(tick), .ext_clk_sel_o(ext_sel),
    .dac_code_o(dac), .st_run_o(st_run), .st_neg_o(st_neg),
    .st_pos_o(st_pos), .mem_test_run_o(mem_run),
    .gyro_comp_o(gcomp), .accel_align_o(align));

  iodc_host u_host (
    .clk_sys_i(clk_sys_i), .rd_data_i(rd_data), .wr_en_o(wr_en),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_en_o(rd_en),
    .rd_addr_o(rd_addr));

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic wait_tick();
    int k;
    k = 0;
    while (tick !== 1'b1 && k < 200) begin
      @(negedge clk_sys_i);
      k++;
    end
    chk(16'(tick), 16'h0001);
  endtask

  // readback: written level on outputs, pin level on inputs
  function automatic logic [15:0] gpio_exp(logic [15:0] v, logic [3:0] p);
    return {4'h0, (v[11:8] & v[3:0]) | (p & ~v[3:0]), 4'h0, v[3:0]};
  endfunction

  initial begin
    #(20ns * 30000);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v, w, old;
    logic [5:0]  f;
    int          n, p, t;
    logic        pv;
    bad_count = 0;
    cmp_count = 0;
    arst_n_i = 1'b0;
    line_in = 4'h0;
    alarm = '0;
    dev = '0;
    st_done = 1'b0;
    st_fail = 6'h00;
    mem_done = 1'b0;
    mem_fail = 1'b0;
    void'($urandom(90));
    cyc(20);
    arst_n_i = 1'b1;
    u_host.rd16(IODC_ADDR_MISC, v);
    chk(v, 16'h0006);
    u_host.rd16(IODC_ADDR_GPIO, v);
    chk(v, 16'h0000);
    u_host.rd16(IODC_ADDR_DIAG, v);
    chk(v, 16'h0000);
    chk(16'(line.oe_n), 16'h000E);
    $display("test reset done");

    n = 0;
    while (line.o[0] !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (line.o[0] === 1'b1 && n < 50) begin
      cyc(1);
      n++;
    end
    chk(16'(n), 16'(DRC));
    p = 0;
    t = 0;
    pv = 1'b0;
    for (int i = 0; i < 202; i++) begin
      cyc(1);
      if (i < 200 && tick === 1'b1) t++;
      if (line.o[0] === 1'b1 && !pv) p++;
      pv = line.o[0];
    end
    chk(16'(p), 16'(t));
    chk(16'(t > 0), 16'h0001);
    // reset period: base of 10 cycles times (1 + 1) gives 10 ticks
    chk(16'(t), 16'h000A);
    u_host.wr16(IODC_ADDR_MISC, 16'h0004);
    wait_tick();
    cyc(2);
    chk(16'(line.o[0]), 16'h0000);
    cyc(DRC);
    chk(16'(line.o[0]), 16'h0001);
    u_host.wr16(IODC_ADDR_MISC, 16'h0007);
    cyc(2);
    chk(16'(line.oe_n[1:0]), 16'h0001);
    $display("test data ready done");

    u_host.wr16(IODC_ADDR_MISC, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      v = 16'($urandom());
      line_in = 4'($urandom());
      u_host.wr16(IODC_ADDR_GPIO, v);
      cyc(2);
      u_host.rd16(IODC_ADDR_GPIO, w);
      chk(w, gpio_exp(v, line_in));
      chk(16'(line.oe_n), {12'h000, ~v[3:0]});
      chk(16'(line.o & v[3:0]), 16'(v[11:8] & v[3:0]));
    end
    $display("test gpio done");

    u_host.wr16(IODC_ADDR_GPIO, 16'h0101);
    alarm = '{en: 1'b1, pol: 1'b1, sel: 1'b0, active: 1'b0};
    u_host.wr16(IODC_ADDR_MISC, 16'h0006);
    wait_tick();
    cyc(2);
    chk(16'(line.o[0]), 16'h0001);
    u_host.wr16(IODC_ADDR_MISC, 16'h0000);
    cyc(2);
    chk(16'(line.o[0]), 16'h0000);
    alarm.en = 1'b0;
    cyc(2);
    chk(16'(line.o[0]), 16'h0001);
    $display("test priority done");

    u_host.wr16(IODC_ADDR_SMPL, 16'h0000);
    u_host.wr16(IODC_ADDR_GPIO, 16'h0008);
    cyc(1);
    chk(16'(ext_sel), 16'h0000);
    u_host.wr16(IODC_ADDR_GPIO, 16'h0000);
    cyc(1);
    chk(16'(ext_sel), 16'h0001);
    line_in[3] = 1'b0;
    cyc(2);
    line_in[3] = 1'b1;
    cyc(1);
    chk(16'(tick), 16'h0001);
    u_host.wr16(IODC_ADDR_SMPL, 16'h0080);
    cyc(1);
    chk(16'(ext_sel), 16'h0000);
    u_host.wr16(IODC_ADDR_SMPL, 16'h0001);
    $display("test sample clock done");

    old = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom());
      // both bytes land before the latch command
      u_host.wr16(IODC_ADDR_AUX, v);
      chk(16'(dac), old);
      u_host.wr16(IODC_ADDR_GCMD, 16'h0004);
      chk(16'(dac), v & 16'h0FFF);
      u_host.rd16(IODC_ADDR_AUX, w);
      chk(w, v & 16'h0FFF);
      u_host.rd16(IODC_ADDR_GCMD, w);
      chk(w, 16'h0000);
      old = v & 16'h0FFF;
    end
    $display("test converter done");

    for (int i = 0; i < 4; i++) begin
      v = {6'h00, 4'($urandom()), 6'h06};
      u_host.wr16(IODC_ADDR_MISC, v);
      chk(16'({st_neg, st_pos}), 16'(v[9:8]));
      chk(16'({gcomp, align}), 16'(v[7:6]));
    end
    u_host.wr16(IODC_ADDR_MISC, 16'h0406);
    chk(16'(st_run), 16'h0001);
    f = 6'($urandom()) | 6'h01;
    st_fail = f;
    st_done = 1'b1;
    cyc(1);
    st_done = 1'b0;
    cyc(2);
    u_host.rd16(IODC_ADDR_MISC, w);
    chk(w, 16'h0006);
    u_host.rd16(IODC_ADDR_DIAG, w);
    chk(w & 16'hFC20, {f, 10'h020});
    u_host.wr16(IODC_ADDR_MISC, 16'h0806);
    chk(16'(mem_run), 16'h0001);
    mem_fail = 1'b1;
    mem_done = 1'b1;
    cyc(1);
    mem_done = 1'b0;
    cyc(2);
    u_host.rd16(IODC_ADDR_MISC, w);
    chk(w, 16'h0006);
    u_host.rd16(IODC_ADDR_DIAG, w);
    chk(w & 16'h0040, 16'h0040);
    u_host.rd16(IODC_ADDR_DIAG, w);
    chk(w, 16'h0000);
    $display("test self-test done");

    wait_tick();
    dev = 7'h7F;
    wait_tick();
    cyc(1);
    u_host.rd16(IODC_ADDR_DIAG, w);
    chk(w, 16'h031F);
    dev = 7'h12;
    cyc(1);
    u_host.rd16(IODC_ADDR_DIAG, w);
    chk(w, 16'h0002);
    wait_tick();
    cyc(1);
    u_host.rd16(IODC_ADDR_DIAG, w);
    chk(w, 16'h0012);
    dev = 7'h00;
    cyc(2);
    u_host.rd16(IODC_ADDR_DIAG, w);
    chk(w, 16'h0000);
    $display("test status done");
    close_out();
  end
endmodule
